// file: core/lsd_pkg.sv
// Package for the LCD serial command decoder: constants, types, states
package lsd_pkg;
  // ----------------------------------------------------------------
  // Command opcodes and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] LSD_BLANK_CMD = 8'h08;
  localparam logic [7:0] LSD_SHOW_CMD = 8'h09;
  localparam logic [7:0] LSD_CHAR_MODE_CMD = 8'h72;
  localparam logic [4:0] LSD_FRAME_RATE_PFX = 5'h02;
  localparam logic [4:0] LSD_MULTIPLEX_PFX = 5'h03;
  localparam logic [5:0] LSD_READ_PFX = 6'h18;
  localparam logic [5:0] LSD_WRITE_PFX = 6'h19;
  localparam logic [5:0] LSD_AND_PFX = 6'h1B;
  localparam logic [5:0] LSD_OR_PFX = 6'h1A;
  localparam logic [2:0] LSD_BIT_SET_PFX = 3'h2;
  localparam logic [2:0] LSD_BIT_CLEAR_PFX = 3'h1;
  // ----------------------------------------------------------------
  // Pointer step codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LSD_STEP_INC = 2'h0;
  localparam logic [1:0] LSD_STEP_DEC = 2'h1;
  localparam logic [1:0] LSD_STEP_BAD = 2'h2;
  localparam logic [1:0] LSD_STEP_HOLD = 2'h3;
  localparam logic [6:0] LSD_CHAR_STEP = 7'h05;
  // ----------------------------------------------------------------
  // Sizes, resets, frame divide
  // ----------------------------------------------------------------
  localparam int LSD_BITS_PER_BYTE = 8;
  localparam logic [2:0] LSD_BIT_LAST = 3'h7;
  localparam int LSD_DIV_BASE = 14;
  localparam logic [2:0] LSD_FRAME_FIELD_MAX = 3'h4;
  localparam logic [2:0] LSD_FRAME_RST = 3'h0;
  localparam logic [2:0] LSD_MUX_RST = 3'h0;
  localparam logic [6:0] LSD_PTR_RST = 7'h00;
  localparam int LSD_DIV_W = 14;

  typedef enum logic [4:0] {
    LSD_MODE_WRITE = 5'b00001,
    LSD_MODE_READ = 5'b00010,
    LSD_MODE_AND = 5'b00100,
    LSD_MODE_OR = 5'b01000,
    LSD_MODE_CHAR = 5'b10000
  } lsd_mode_e;

  typedef enum logic [3:0] {
    LSD_ST_IDLE = 4'b0001,
    LSD_ST_FETCH = 4'b0010,
    LSD_ST_EXEC = 4'b0100,
    LSD_ST_RELOAD = 4'b1000
  } lsd_state_e;

  // Display configuration as seen by the panel drive
  typedef struct packed {
    logic display_on;
    logic [2:0] frame_divide_field;
    logic mux16;
    logic sync_out;
    logic upper_rows;
    logic bank;
  } lsd_cfg_s;

  // Memory port request
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } lsd_mem_req_s;
endpackage

// file: core/lsd_mem.sv
// Display memory: 128 bytes, registered read data
`timescale 1ns/1ps
`default_nettype none
module lsd_mem #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic core_clk,
  input wire lsd_pkg::lsd_mem_req_s req,
  output logic [7:0] rdata
);
  import lsd_pkg::*;
  logic [7:0] store [DEPTH];

  always_ff @(posedge core_clk) begin
    if (req.we) begin
      store[req.addr[AW-1:0]] <= req.wdata;
    end
    rdata <= store[req.addr[AW-1:0]];
  end
endmodule
`default_nettype wire

// file: core/lsd_frame.sv
// Frame-rate divider and master/slave frame sync
`timescale 1ns/1ps
`default_nettype none
module lsd_frame (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] frame_divide_field,
  input wire logic sync_out,
  input wire logic sync_pulse_in,
  output logic frame_tick
);
  import lsd_pkg::*;
  logic [LSD_DIV_W-1:0] count;
  logic [3:0] shift_amt;
  logic [LSD_DIV_W-1:0] limit;
  logic wrap;
  logic [2:0] field_eff;

  assign field_eff = (frame_divide_field > LSD_FRAME_FIELD_MAX) ?
    LSD_FRAME_FIELD_MAX : frame_divide_field;
  assign shift_amt = 4'(LSD_DIV_BASE) - {1'b0, field_eff};
  assign limit = LSD_DIV_W'((15'h1 << shift_amt) - 15'h1);
  assign wrap = (count == limit);

  // slaves realign on the master pulse
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      frame_tick <= 1'b0;
    end else if (!sync_out && sync_pulse_in) begin
      count <= '0;
      frame_tick <= 1'b1;
    end else begin
      count <= wrap ? '0 : count + 1'b1;
      frame_tick <= wrap;
    end
  end
endmodule
`default_nettype wire

// file: core/lsd_core.sv
// LCD serial command decoder: serial link, commands, memory ops
// Functional notes
// - Read mode with select low drives read data; otherwise busy shows.
// - Shared output floats while chip select is high.
// - Serial clock edges are ignored while chip select is high.
// - Transfers happen only while host holds chip select low.
// - Select low is data, high is command; read-mode data input invalid.
// - Master drives a frame sync pulse; slaves realign to it.
// - Active-high reset input resets the device.
// - Frame rate is clock divided by 2^(14-F), F 0 to 4.
// - Multiplex command sets mux count, row half, sync direction, bank.
// - Display-off blanks panel drive; memory kept.
// - Display-on resumes panel drive from memory.
// - Step code 00 inc, 01 dec, 11 hold; applies per data byte.
// - Data mode persists until another data-mode command.
// - Read-mode command enters read mode and loads pointed byte.
// - Write mode stores each data byte unchanged.
// - AND mode ANDs data with pointed byte and writes back.
// - OR mode ORs data with pointed byte and writes back.
// - Character mode writes font_bits[6:0] to the pointed byte, pointer advances by five.
// - Bit-set sets indexed bit of pointed byte then steps pointer.
// - Bit command step is one-shot; previous mode and step remain.
// - Bit-clear clears indexed bit then steps pointer.
// - Input sampled MSB first on rise; eighth rise dispatches, busy asserts.
// - Read data shifts out MSB first on fall; reload after eighth.
// - Pointer-load with top bit one loads low seven bits.
// - Character writes keep memory bit seven unchanged.
`timescale 1ns/1ps
`default_nettype none
module lsd_core (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic serial_in,
  input wire logic serial_clk,
  input wire logic command_data_select,
  input wire logic chip_select_n,
  input wire logic sync_in,
  input wire logic [34:0] font_bits,
  output logic [7:0] font_code,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic sync_o,
  output logic sync_oe_n,
  output lsd_pkg::lsd_cfg_s cfg,
  output logic frame_pulse
);
  import lsd_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers (three stages)
  // ----------------------------------------------------------------
  logic [2:0] sck_s, cs_s, si_s, cd_s, sy_s;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // Serial clock idles high; no false edge after reset
      sck_s <= 3'h7;
      cs_s <= 3'h7;
      si_s <= 3'h0;
      cd_s <= 3'h0;
      sy_s <= 3'h0;
    end else begin
      sck_s <= {sck_s[1:0], serial_clk};
      cs_s <= {cs_s[1:0], chip_select_n};
      si_s <= {si_s[1:0], serial_in};
      cd_s <= {cd_s[1:0], command_data_select};
      sy_s <= {sy_s[1:0], sync_in};
    end
  end

  logic sck_lvl, cs_n_lvl, si_lvl, cd_lvl, sy_lvl, sy_prev;
  logic sck_prev;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sck_lvl <= 1'b1;
      sck_prev <= 1'b1;
      cs_n_lvl <= 1'b1;
      si_lvl <= 1'b0;
      cd_lvl <= 1'b0;
      sy_lvl <= 1'b0;
      sy_prev <= 1'b0;
    end else begin
      if (sck_s[1] == sck_s[2]) sck_lvl <= sck_s[2];
      if (cs_s[1] == cs_s[2]) cs_n_lvl <= cs_s[2];
      if (si_s[1] == si_s[2]) si_lvl <= si_s[2];
      if (cd_s[1] == cd_s[2]) cd_lvl <= cd_s[2];
      if (sy_s[1] == sy_s[2]) sy_lvl <= sy_s[2];
      sck_prev <= sck_lvl;
      sy_prev <= sy_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Edge decode and state
  // ----------------------------------------------------------------
  lsd_state_e state, next_state;
  lsd_mode_e mode;
  logic busy;
  logic [2:0] bit_count;
  logic [7:0] shift_reg;
  logic [1:0] mode_step;
  logic [6:0] pointer;
  logic [7:0] cmd_byte;
  logic cmd_is_cmd;
  logic [7:0] mem_rdata;
  lsd_mem_req_s mem_req;

  wire sck_rise = sck_lvl && !sck_prev;
  wire sck_fall = !sck_lvl && sck_prev;
  wire link_on = !cs_n_lvl;
  wire take_rise = link_on && sck_rise && !busy;
  wire take_fall = link_on && sck_fall && !busy;
  wire byte_done = take_rise && (bit_count == LSD_BIT_LAST);
  wire read_mode = (mode == LSD_MODE_READ);
  wire out_phase = read_mode && !cd_lvl;

  function automatic logic [6:0] step_ptr(input logic [6:0] p,
                                          input logic [1:0] code);
    case (code)
      LSD_STEP_INC: step_ptr = p + 7'h01;
      LSD_STEP_DEC: step_ptr = p - 7'h01;
      default: step_ptr = p;
    endcase
  endfunction

  // Command decode wires
  wire is_ptr_load = cmd_byte[7];
  wire is_frame = cmd_byte[7:3] == LSD_FRAME_RATE_PFX;
  wire is_mux = cmd_byte[7:3] == LSD_MULTIPLEX_PFX;
  wire is_blank = cmd_byte == LSD_BLANK_CMD;
  wire is_show = cmd_byte == LSD_SHOW_CMD;
  wire is_read = cmd_byte[7:2] == LSD_READ_PFX;
  wire is_write = cmd_byte[7:2] == LSD_WRITE_PFX;
  wire is_and = cmd_byte[7:2] == LSD_AND_PFX;
  wire is_or = cmd_byte[7:2] == LSD_OR_PFX;
  wire is_char = cmd_byte == LSD_CHAR_MODE_CMD;
  wire is_bit_set_cmd = cmd_byte[7:5] == LSD_BIT_SET_PFX;
  wire is_bclr = cmd_byte[7:5] == LSD_BIT_CLEAR_PFX;
  wire is_bit = is_bit_set_cmd || is_bclr;
  // Pointer load waits a cycle so the reload sees the new address
  wire needs_mem = !cmd_is_cmd || is_bit || is_ptr_load;
  wire [7:0] bit_mask = 8'h01 << cmd_byte[4:2];

  // Memory write data per operation
  logic [7:0] char_byte;
  assign char_byte = {mem_rdata[7], font_bits[6:0]};
  logic [7:0] op_data;
  assign op_data =
    (cmd_is_cmd && is_bit_set_cmd) ? (mem_rdata | bit_mask) :
    (cmd_is_cmd) ? (mem_rdata & ~bit_mask) :
    (mode == LSD_MODE_AND) ? (mem_rdata & cmd_byte) :
    (mode == LSD_MODE_OR) ? (mem_rdata | cmd_byte) :
    (mode == LSD_MODE_CHAR) ? char_byte : cmd_byte;
  wire exec_we = (state == LSD_ST_EXEC) &&
    (cmd_is_cmd ? is_bit : !read_mode);

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      LSD_ST_IDLE: if (byte_done) next_state = LSD_ST_FETCH;
      LSD_ST_FETCH: next_state = needs_mem ? LSD_ST_EXEC : LSD_ST_RELOAD;
      LSD_ST_EXEC: next_state = LSD_ST_RELOAD;
      LSD_ST_RELOAD: next_state = LSD_ST_IDLE;
      default: next_state = LSD_ST_IDLE;
    endcase
  end

  assign mem_req.we = exec_we;
  assign mem_req.addr = pointer;
  assign mem_req.wdata = op_data;

  // ----------------------------------------------------------------
  // Serial shift path
  // ----------------------------------------------------------------
  // idle, released, cleared at reset
  // reset high clears all control state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= LSD_ST_IDLE;
      bit_count <= 3'h0;
      shift_reg <= 8'h00;
      busy <= 1'b0;
      cmd_byte <= 8'h00;
      cmd_is_cmd <= 1'b0;
    end else begin
      state <= next_state;
      if (!link_on && !busy) bit_count <= 3'h0;
      // MSB first on rise, dispatch on eighth
      else if (take_rise) bit_count <= bit_count + 3'h1;
      if (take_rise && !out_phase) begin
        shift_reg <= {shift_reg[6:0], si_lvl};
      end
      // MSB stands until the second fall
      if (take_fall && out_phase && bit_count != 3'h0) begin
        shift_reg <= {shift_reg[6:0], 1'b0};
      end
      if (byte_done) begin
        busy <= 1'b1;
        cmd_byte <= {shift_reg[6:0], si_lvl};
        cmd_is_cmd <= cd_lvl;
      end
      // load pointed byte in read mode
      if (state == LSD_ST_RELOAD) begin
        busy <= 1'b0;
        if (read_mode) shift_reg <= mem_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  wire do_cmd = (state == LSD_ST_FETCH) && cmd_is_cmd;
  wire data_step = (state == LSD_ST_FETCH) && !cmd_is_cmd;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode <= LSD_MODE_WRITE;
      mode_step <= LSD_STEP_INC;
      pointer <= LSD_PTR_RST;
      cfg <= '{1'b0, LSD_FRAME_RST, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      if (do_cmd && is_ptr_load) pointer <= cmd_byte[6:0];
      if (do_cmd && is_frame) cfg.frame_divide_field <= cmd_byte[2:0];
      if (do_cmd && is_mux) begin
        cfg.mux16 <= cmd_byte[2];
        cfg.sync_out <= cmd_byte[1];
        cfg.upper_rows <= cmd_byte[2] && !cmd_byte[1];
        cfg.bank <= cmd_byte[2] ? 1'b0 : cmd_byte[0];
      end
      if (do_cmd && is_blank) cfg.display_on <= 1'b0;
      if (do_cmd && is_show) cfg.display_on <= 1'b1;
      // data mode persists until a new mode command
      if (do_cmd && (is_read || is_write || is_and || is_or)) begin
        mode_step <= cmd_byte[1:0];
      end
      if (do_cmd && is_read) mode <= LSD_MODE_READ;
      if (do_cmd && is_write) mode <= LSD_MODE_WRITE;
      if (do_cmd && is_and) mode <= LSD_MODE_AND;
      if (do_cmd && is_or) mode <= LSD_MODE_OR;
      if (do_cmd && is_char) mode <= LSD_MODE_CHAR;
      // bit ops step after the write
      if (state == LSD_ST_EXEC && cmd_is_cmd && is_bit) begin
        pointer <= step_ptr(pointer, cmd_byte[1:0]);
      end
      if (state == LSD_ST_EXEC && !cmd_is_cmd && !read_mode) begin
        if (mode == LSD_MODE_CHAR) pointer <= pointer + LSD_CHAR_STEP;
        else pointer <= step_ptr(pointer, mode_step);
      end
      // data in read mode is a read, then step
      if (data_step && read_mode) pointer <= step_ptr(pointer, mode_step);
    end
  end

  lsd_mem u_mem (
    .core_clk(core_clk),
    .req(mem_req),
    .rdata(mem_rdata)
  );

  logic frame_tick;
  lsd_frame u_frame (
    .core_clk(core_clk),
    .reset(reset),
    .frame_divide_field(cfg.frame_divide_field),
    .sync_out(cfg.sync_out),
    .sync_pulse_in(sy_lvl && !sy_prev),
    .frame_tick(frame_tick)
  );

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  wire so_sel = read_mode && !cd_lvl;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      serial_out <= 1'b1;
      serial_out_oe_n <= 1'b1;
      sync_o <= 1'b0;
      sync_oe_n <= 1'b1;
      frame_pulse <= 1'b0;
      font_code <= 8'h00;
    end else begin
      // read data or busy (busy low when busy)
      serial_out <= so_sel ? shift_reg[7] : !busy;
      serial_out_oe_n <= cs_n_lvl;
      // master drives one pulse per frame
      sync_o <= frame_tick && cfg.sync_out;
      sync_oe_n <= !cfg.sync_out;
      frame_pulse <= frame_tick;
      font_code <= cmd_byte;
    end
  end
endmodule
`default_nettype wire

// file: test/lsd_props.sv
// Port checker for the LCD serial command decoder
`timescale 1ns/1ps
`default_nettype none
module lsd_props
  import lsd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic serial_in,
  input wire logic serial_clk,
  input wire logic command_data_select,
  input wire logic chip_select_n,
  input wire logic sync_in,
  input wire logic [34:0] font_bits,
  input wire logic [7:0] font_code,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic sync_o,
  input wire logic sync_oe_n,
  input wire lsd_pkg::lsd_cfg_s cfg,
  input wire logic frame_pulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Frame gap measurement
  // ----------------------------------------------------------------
  logic [15:0] gap;
  logic seen;
  lsd_cfg_s cfg_q;
  logic [2:0] fcl;
  logic [15:0] period;
  assign fcl = (cfg.frame_divide_field > 3'h4) ? 3'h4 : cfg.frame_divide_field;
  assign period = 16'h0001 << (5'h0E - {2'h0, fcl});
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      gap <= 16'h0000;
      seen <= 1'b0;
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg;
      gap <= frame_pulse ? 16'h0001 : gap + 16'h0001;
      seen <= (cfg != cfg_q || (sync_in && sync_oe_n)) ? 1'b0 :
              (frame_pulse ? 1'b1 : seen);
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_float_deselect: assert property (
    chip_select_n [*8] |-> serial_out_oe_n) else $error("pin not floating");
  a_drive_selected: assert property (
    !chip_select_n [*8] |-> !serial_out_oe_n) else $error("pin not driven");
  a_idle_reset: assert property (
    $fell(reset) |-> serial_out && !cfg.display_on)
    else $error("not idle after reset");
  a_busy_short: assert property (
    $fell(serial_out) && command_data_select && !serial_out_oe_n
    |-> ##[1:6] serial_out) else $error("busy not released");
  a_cfg_by_cmd: assert property (
    $changed(cfg) |-> command_data_select && !chip_select_n)
    else $error("config changed without command");
  a_pulse_single: assert property (
    frame_pulse |=> !frame_pulse) else $error("frame pulse too long");
  a_frame_period: assert property (
    frame_pulse && seen |-> gap == period) else $error("frame period off");
  a_sync_dir: assert property (
    $stable(cfg.sync_out) [*4] |-> sync_oe_n == !cfg.sync_out)
    else $error("sync direction wrong");
  a_sync_master: assert property (
    sync_o |-> !sync_oe_n && $past(cfg.sync_out))
    else $error("sync pulse as slave");
  cover property (frame_pulse && seen);
  cover property ($fell(serial_out) && command_data_select);
  cover property (cfg.display_on);
  cover property (sync_o);
endmodule
`default_nettype wire

// file: test/lsd_host.sv
// Host model driving the synchronous serial link
`timescale 1ns/1ps
`default_nettype none
module lsd_host #(
  parameter int HALF = 10
) (
  input wire logic core_clk,
  input wire logic so,
  output logic sck,
  output logic si,
  output logic cd,
  output logic cs_n,
  output logic hang
);
  initial begin
    sck = 1'b1;
    si = 1'b0;
    cd = 1'b1;
    cs_n = 1'b1;
    hang = 1'b0;
  end
  task select(input logic v);
    @(posedge core_clk);
    #1 cs_n = v;
  endtask
  task wait_ready();
    int n;
    n = 0;
    repeat (HALF) @(posedge core_clk);
    while (so !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n == 200) hang = 1'b1;
  endtask
  // select level marks data or command
  task xfer(input logic cdv, input logic [7:0] wr, output logic [7:0] rd);
    @(posedge core_clk);
    #1 cd = cdv;
    repeat (HALF) @(posedge core_clk);
    for (int i = 7; i >= 0; i--) begin
      #1 sck = 1'b0;
      si = wr[i];
      repeat (HALF) @(posedge core_clk);
      #1 rd[i] = so;
      sck = 1'b1;
      repeat (HALF) @(posedge core_clk);
    end
    repeat (HALF) @(posedge core_clk);
    #1 si = ~si;
    cd = 1'b1;
    wait_ready();
  endtask
  // Clock pulses meant to be ignored
  task glitch(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk);
      #1 sck = 1'b0;
      si = ~si;
      repeat (HALF) @(posedge core_clk);
      #1 sck = 1'b1;
      repeat (HALF) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// Testbench for the LCD serial command decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lsd_pkg::*;
  logic core_clk, reset, sync_drv, serial_out, serial_out_oe_n;
  logic sync_o, sync_oe_n, frame_pulse;
  logic [7:0] font_code, rd;
  logic [2:0] mx;
  lsd_cfg_s cfg;
  wire logic sck, si, cd, cs_n, so_w, sync_w, hang;
  wire logic [34:0] font_bits;
  int fail_count, n_tests, cycles, k;
  logic [8:0] seq [26] = '{9'h185, 9'h164, 9'h0AA, 9'h055, 9'h00F,
    9'h165, 9'h033, 9'h15C, 9'h066, 9'h122, 9'h158, 9'h185, 9'h16C,
    9'h0F0, 9'h16B, 9'h080, 9'h002, 9'h18A, 9'h164, 9'h080, 9'h18A,
    9'h172, 9'h041, 9'h167, 9'h099, 9'h109};
  logic [7:0] rexp [4] = '{8'hA0, 8'hD7, 8'hCE, 8'h66};
  assign so_w = serial_out_oe_n ? ~serial_out : serial_out;
  assign sync_w = sync_oe_n ? sync_drv : sync_o;
  assign font_bits = {5{font_code[6:0] ^ 7'h2A}};
  lsd_core dut (.core_clk(core_clk), .reset(reset), .serial_in(si),
    .serial_clk(sck), .command_data_select(cd), .chip_select_n(cs_n),
    .sync_in(sync_w), .font_bits(font_bits), .font_code(font_code),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .sync_o(sync_o), .sync_oe_n(sync_oe_n), .cfg(cfg),
    .frame_pulse(frame_pulse));
  lsd_host u_host (.core_clk(core_clk), .so(so_w), .sck(sck), .si(si),
    .cd(cd), .cs_n(cs_n), .hang(hang));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic wrap_up();
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic send(input logic cdv, input logic [7:0] b);
    u_host.xfer(cdv, b, rd);
  endtask
  task automatic rdb(input logic [7:0] exp);
    u_host.xfer(1'b0, 8'h3C, rd);
    chk(rd, exp);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    reset = 1'b1;
    sync_drv = 1'b0;
    fail_count = 0;
    n_tests = 0;
    cycles = 0;
    repeat (3) @(posedge core_clk);
    #1 reset = 1'b0;
    repeat (10) @(posedge core_clk);
    chk({7'h00, serial_out_oe_n}, 8'h01);
    chk(cfg, 8'h00);
    u_host.select(1'b0);
    repeat (10) @(posedge core_clk);
    chk({6'h00, serial_out_oe_n, serial_out}, 8'h01);
    send(1'b1, 8'h14);
    chk({5'h00, cfg.frame_divide_field}, 8'h04);
    send(1'b1, LSD_SHOW_CMD);
    chk({7'h00, cfg.display_on}, 8'h01);
    for (int m = 0; m < 8; m++) begin
      mx = 3'(m);
      send(1'b1, {LSD_MULTIPLEX_PFX, mx});
      chk({4'h0, cfg.mux16, cfg.sync_out, cfg.upper_rows, cfg.bank},
        {4'h0, mx[2], mx[1], mx[2] & ~mx[1], ~mx[2] & mx[0]});
    end
    // ----------------------------------------------------------------
    // Memory operations, then readback
    // ----------------------------------------------------------------
    foreach (seq[i]) send(seq[i][8], seq[i][7:0]);
    chk(font_code, LSD_SHOW_CMD);
    u_host.glitch(3);
    u_host.select(1'b1);
    u_host.glitch(3);
    u_host.select(1'b0);
    send(1'b1, LSD_BLANK_CMD);
    chk({7'h00, cfg.display_on}, 8'h00);
    send(1'b1, 8'h85);
    send(1'b1, 8'h60);
    foreach (rexp[i]) rdb(rexp[i]);
    send(1'b1, 8'h8A);
    rdb(8'hEB);
    send(1'b1, 8'h8F);
    rdb(8'h99);
    send(1'b1, 8'h86);
    send(1'b1, 8'h61);
    rdb(8'hD7);
    rdb(8'hA0);
    send(1'b1, {LSD_MULTIPLEX_PFX, 3'h0});
    @(posedge frame_pulse);
    repeat (100) @(posedge core_clk);
    #1 sync_drv = 1'b1;
    k = 0;
    while (!frame_pulse && k < 12) begin
      @(posedge core_clk);
      #1 k++;
    end
    sync_drv = 1'b0;
    chk(8'(k), 8'h06);
    repeat (3000) @(posedge core_clk);
    chk({7'h00, hang}, 8'h00);
    wrap_up();
  end
endmodule
bind lsd_core lsd_props u_props (.core_clk(core_clk), .reset(reset),
  .serial_in(serial_in), .serial_clk(serial_clk),
  .command_data_select(command_data_select),
  .chip_select_n(chip_select_n), .sync_in(sync_in),
  .font_bits(font_bits), .font_code(font_code), .serial_out(serial_out),
  .serial_out_oe_n(serial_out_oe_n), .sync_o(sync_o),
  .sync_oe_n(sync_oe_n), .cfg(cfg), .frame_pulse(frame_pulse));
`default_nettype wire
